// ### smc_mode_ctrl.sv
// Interface detection, reset notification, operating modes and data formatting
`timescale 1ns/100ps
`default_nettype none
module smc_mode_ctrl
	import smc_pkg::*;
#(
	parameter int DETECT_CYC = DETECT_CYCLES,
	parameter int EVENTS     = 8
) (
	input  wire logic                       ref_clk_i,
	input  wire logic                       reset_i,
	input  wire logic                       clk_en_i,
	input  wire logic                       core_supply_ok_i,
	input  wire logic                       soft_reset_i,
	input  wire logic                       addr_lsb_or_serial_out_pin_i,
	input  wire logic                       serial_out_data_i,
	input  wire logic                       serial_sel_active_i,
	input  wire logic                       serial_clk_pin_i,
	input  wire logic                       active_bit_i,
	input  wire logic                       sleep_req_i,
	input  wire logic [EVENTS-1:0]          events_i,
	input  wire logic [EVENTS-1:0]          route_to_second_i,
	input  wire logic [TRIM_W-1:0]          trim_data_i,
	input  wire logic                       trim_valid_i,
	input  wire logic                       fast_read_i,
	input  wire logic [1:0]                 full_scale_i,
	input  wire logic                       low_noise_i,
	input  wire logic [1:0]                 accel_mods_i,
	input  wire logic [2:0]                 mag_osr_i,
	input  wire logic                       mag_8bit_i,
	input  wire logic                       raw_valid_i,
	input  wire logic [AXES-1:0][RAW_W-1:0] accel_raw_i,
	input  wire logic [AXES-1:0][RAW_W-1:0] mag_raw_i,
	input  wire logic [AXES-1:0][7:0]       accel_user_off_i,
	input  wire logic [AXES-1:0][15:0]      mag_user_off_i,
	output logic                            strap_pull_up_o,
	output logic                            serial_out_o,
	output logic                            serial_out_oe_n_o,
	output logic                            spi_mode_o,
	output logic                            bus_enable_o,
	output logic                            serial_clk_rise_o,
	output logic                            first_interrupt_pin_o,
	output logic                            second_interrupt_pin_o,
	output logic                            digital_en_o,
	output logic                            analog_en_o,
	output logic                            subset_reset_o,
	output logic                            sleeping_o,
	output logic                            trim_rd_o,
	output logic [2:0]                      trim_addr_o,
	output logic [1:0]                      eff_full_scale_o,
	output logic [1:0]                      accel_osr_o,
	output logic [2:0]                      mag_osr_o,
	output logic                            skip_low_bytes_o,
	output logic                            mag_wide_o,
	output logic [AXES-1:0][7:0]            accel_hi_o,
	output logic [AXES-1:0][7:0]            accel_lo_o,
	output logic [AXES-1:0][7:0]            mag_hi_o,
	output logic [AXES-1:0][7:0]            mag_lo_o
);
	initial begin
		if (DETECT_CYC < 4 || DETECT_CYC > 65535) $error("smc_mode_ctrl: DETECT_CYC out of range");
		if (EVENTS < 1) $error("smc_mode_ctrl: EVENTS must be positive");
	end

	typedef enum logic [2:0] {ST_OFF, ST_DETECT, ST_TRIM, ST_NOTIFY, ST_RUN} smc_state_t;

	localparam logic [15:0] DET_LAST = 16'(DETECT_CYC - 1);
	localparam logic [15:0] DET_HALF = 16'(DETECT_CYC / 2);
	localparam logic [3:0]  NOTE_LAST = 4'(NOTIFY_LOW_CYCLES - 1);

	// ----------------------------------------------------------------
	// Synchronisers for pins and the supply monitor
	// ----------------------------------------------------------------
	logic [2:0] meta_reg;
	logic [2:0] sync_reg;
	logic       sclk_prev_reg;
	logic       core_ok;
	logic       strap_level;
	logic       sclk_level;

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			meta_reg      <= '0;
			sync_reg      <= '0;
			sclk_prev_reg <= 1'b0;
		end else if (clk_en_i) begin
			meta_reg      <= {serial_clk_pin_i, addr_lsb_or_serial_out_pin_i, core_supply_ok_i};
			sync_reg      <= meta_reg;
			sclk_prev_reg <= sync_reg[2];
		end
	end
	assign core_ok     = sync_reg[0];
	assign strap_level = sync_reg[1];
	assign sclk_level  = sync_reg[2];

	// ----------------------------------------------------------------
	// Reset sequence: detect, trim load, notify
	// ----------------------------------------------------------------
	smc_state_t state_reg, state_next;
	logic [15:0]       det_cnt_reg;
	logic [3:0]        note_cnt_reg;
	logic              up_sample_reg;
	logic              spi_reg;
	logic              pulse_low_reg;
	logic [2:0]        trim_idx_reg;
	logic              trim_rd_reg;
	logic              trim_wait_reg;
	logic [TRIM_W-1:0] trim_reg [TRIM_WORDS];
	logic              restart;
	logic              det_done;
	logic              trim_done;
	logic              note_done;
	logic              floating;

	assign restart   = !core_ok || soft_reset_i;
	assign det_done  = (state_reg == ST_DETECT) && (det_cnt_reg == DET_LAST);
	assign trim_done = trim_valid_i && (trim_idx_reg == 3'(TRIM_WORDS - 1));
	assign note_done = !pulse_low_reg || (note_cnt_reg == NOTE_LAST);
	// Pin follows the weak pull both ways only when nothing holds it
	assign floating  = up_sample_reg && !strap_level;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_OFF:    if (core_ok) state_next = ST_DETECT;
			ST_DETECT: if (det_done) state_next = ST_TRIM;
			ST_TRIM:   if (trim_done) state_next = ST_NOTIFY;
			ST_NOTIFY: if (note_done) state_next = ST_RUN;
			ST_RUN:    state_next = ST_RUN;
		endcase
		if (!core_ok) state_next = ST_OFF;
		else if (soft_reset_i) state_next = ST_DETECT;
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg <= ST_OFF;
		end else if (clk_en_i) begin
			state_reg <= state_next;
		end
	end

	// Strap pulled up for the first half of the window, down for the second
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			det_cnt_reg   <= '0;
			up_sample_reg <= 1'b0;
			spi_reg       <= 1'b0;
		end else if (clk_en_i) begin
			if (state_reg != ST_DETECT || restart) begin
				det_cnt_reg <= '0;
			end else begin
				det_cnt_reg <= det_cnt_reg + 16'h0001;
			end
			if (state_reg == ST_DETECT && det_cnt_reg == DET_HALF) begin
				up_sample_reg <= strap_level;
			end
			if (det_done && !restart) begin
				spi_reg <= floating;
			end
		end
	end

	// Trim words arrive one per read; one read stays outstanding until trim_valid_i
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			trim_idx_reg  <= '0;
			trim_rd_reg   <= 1'b0;
			trim_wait_reg <= 1'b0;
			for (int i = 0; i < TRIM_WORDS; i++) trim_reg[i] <= '0;
		end else if (clk_en_i) begin
			trim_rd_reg <= (state_next == ST_TRIM) && !restart && !trim_valid_i && !trim_rd_reg &&
			               !trim_wait_reg;
			trim_wait_reg <= (trim_wait_reg || trim_rd_reg) && !trim_valid_i && !restart;
			if (state_reg != ST_TRIM) begin
				trim_idx_reg <= '0;
			end else if (trim_valid_i) begin
				trim_reg[trim_idx_reg] <= trim_data_i;
				trim_idx_reg           <= trim_idx_reg + 3'h1;
			end
		end
	end

	// Soft reset remembers the pin level; after a hard reset the pin sits low
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pulse_low_reg <= 1'b0;
			note_cnt_reg  <= '0;
		end else if (clk_en_i) begin
			if (soft_reset_i) begin
				pulse_low_reg <= first_interrupt_pin_o;
			end else if (!core_ok) begin
				pulse_low_reg <= 1'b0;
			end
			if (state_reg == ST_NOTIFY) begin
				note_cnt_reg <= note_cnt_reg + 4'h1;
			end else begin
				note_cnt_reg <= '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Operating modes and interrupt pins
	// ----------------------------------------------------------------
	logic       run;
	logic       act;
	logic       act_prev_reg;
	logic       first_interrupt_pin_next;
	logic       int2_next;
	logic [1:0] eff_fs;
	logic       pin_drive_next;

	assign run = (state_reg == ST_RUN);
	assign act = run && active_bit_i;
	// Pins idle high and pull low on an event, so the notify pulse ends at the idle level
	assign int2_next = !(act && |(events_i & route_to_second_i));
	assign first_interrupt_pin_next = (state_reg == ST_NOTIFY) ? !(pulse_low_reg && !note_done) :
	                   (state_reg == ST_RUN) ? !(act && |(events_i & ~route_to_second_i)) :
	                   first_interrupt_pin_o;
	assign eff_fs = (low_noise_i && full_scale_i == FS_8G) ? FS_4G : full_scale_i;
	assign pin_drive_next = run && spi_reg && serial_sel_active_i;

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			act_prev_reg           <= 1'b0;
			first_interrupt_pin_o  <= 1'b0;
			second_interrupt_pin_o <= 1'b0;
			digital_en_o           <= 1'b0;
			analog_en_o            <= 1'b0;
			subset_reset_o         <= 1'b0;
			sleeping_o             <= 1'b0;
			bus_enable_o           <= 1'b0;
			serial_clk_rise_o      <= 1'b0;
			serial_out_o           <= 1'b0;
			serial_out_oe_n_o      <= 1'b1;
			strap_pull_up_o        <= 1'b1;
		end else if (clk_en_i) begin
			act_prev_reg           <= act;
			first_interrupt_pin_o  <= first_interrupt_pin_next;
			second_interrupt_pin_o <= int2_next;
			digital_en_o           <= core_ok;
			analog_en_o            <= act;
			subset_reset_o         <= act && !act_prev_reg;
			sleeping_o             <= act && sleep_req_i;
			bus_enable_o           <= run;
			serial_clk_rise_o      <= run && sclk_level && !sclk_prev_reg;
			serial_out_o           <= serial_out_data_i;
			serial_out_oe_n_o      <= !pin_drive_next;
			strap_pull_up_o        <= !(state_reg == ST_DETECT && det_cnt_reg >= DET_HALF);
		end
	end

	// ----------------------------------------------------------------
	// Format and oversampling settings
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			eff_full_scale_o <= FS_2G;
			accel_osr_o      <= '0;
			mag_osr_o        <= '0;
			skip_low_bytes_o <= 1'b0;
			mag_wide_o       <= 1'b1;
		end else if (clk_en_i) begin
			eff_full_scale_o <= eff_fs;
			accel_osr_o      <= accel_mods_i;
			mag_osr_o        <= mag_osr_i;
			skip_low_bytes_o <= fast_read_i;
			mag_wide_o       <= !mag_8bit_i;
		end
	end

	// ----------------------------------------------------------------
	// Per-axis compensation
	// ----------------------------------------------------------------
	logic load;
	assign load = act && raw_valid_i;

	for (genvar a = 0; a < AXES; a++) begin : g_axis
		logic signed [ACC_W-1:0] acc;
		logic signed [MAG_W-1:0] mag;

		// Raw counts are 0.244 mg; a shift of two gives 0.976 mg at 8 g
		smc_axis_comp #(.IN_W(RAW_W), .OUT_W(ACC_W)) u_acc (
			.ref_clk_i     (ref_clk_i),
			.reset_i       (reset_i),
			.clk_en_i      (clk_en_i),
			.load_i        (load),
			.raw_i         (accel_raw_i[a]),
			.factory_off_i (trim_reg[a]),
			.user_off_i    (RAW_W'(signed'(accel_user_off_i[a]))),
			.shift_i       (eff_fs),
			.comp_o        (acc)
		);
		smc_axis_comp #(.IN_W(RAW_W), .OUT_W(MAG_W)) u_mag (
			.ref_clk_i     (ref_clk_i),
			.reset_i       (reset_i),
			.clk_en_i      (clk_en_i),
			.load_i        (load),
			.raw_i         (mag_raw_i[a]),
			.factory_off_i (trim_reg[a + AXES]),
			.user_off_i    (mag_user_off_i[a]),
			.shift_i       (2'h0),
			.comp_o        (mag)
		);
		// Upper eight bits alone are the fast-read result, 64 times coarser for accel, 256 times for mag
		assign accel_hi_o[a] = acc[ACC_W-1:ACC_W-8];
		assign accel_lo_o[a] = {acc[ACC_W-9:0], ACC_LO_PAD'(0)};
		assign mag_hi_o[a]   = mag[MAG_W-1:MAG_W-8];
		assign mag_lo_o[a]   = mag[7:0];
	end

	assign spi_mode_o  = spi_reg;
	assign trim_rd_o   = trim_rd_reg;
	assign trim_addr_o = trim_idx_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	logic [3:0] low_run_reg;
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) low_run_reg <= '0;
		else if (clk_en_i) low_run_reg <= (state_reg == ST_NOTIFY && !first_interrupt_pin_o) ?
		                                  low_run_reg + 4'h1 : '0;
	end

	a_spi_choice: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && det_done && !restart |=> spi_reg == $past(floating))
		else $error("interface choice not taken from strap");
	a_choice_held: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		state_reg == ST_RUN && $past(state_reg) == ST_RUN |-> $stable(spi_reg))
		else $error("interface choice changed while running");
	a_notify_len: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		low_run_reg <= 4'(NOTIFY_LOW_CYCLES))
		else $error("reset notify low too long");
	a_notify_rise: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && state_reg == ST_NOTIFY && !pulse_low_reg && core_ok && !soft_reset_i
		|=> first_interrupt_pin_o)
		else $error("reset notify did not rise");
	a_off_quiet: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && !core_ok |=> state_reg == ST_OFF ##1 !bus_enable_o && !analog_en_o)
		else $error("not off with core supply low");
	a_standby: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && run && !active_bit_i |=> !analog_en_o && bus_enable_o)
		else $error("standby state wrong");
	a_subset_rst: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		subset_reset_o |-> analog_en_o && !$past(analog_en_o))
		else $error("subset reset without activation");
	a_sleep_sub: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		sleeping_o |-> analog_en_o)
		else $error("sleep outside active");
	a_ln_range: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && low_noise_i |=> eff_full_scale_o != FS_8G)
		else $error("low noise allowed 8 g");
	a_pin_quiet: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		state_reg == ST_DETECT |-> serial_out_oe_n_o || $past(state_reg) != ST_DETECT)
		else $error("shared pin driven during detection");

	c_spi_run: cover property (@(posedge ref_clk_i) disable iff (reset_i)
		run && spi_reg);
	c_notify_pulse: cover property (@(posedge ref_clk_i) disable iff (reset_i)
		state_reg == ST_NOTIFY && !first_interrupt_pin_o ##1 first_interrupt_pin_o);
	c_activate: cover property (@(posedge ref_clk_i) disable iff (reset_i)
		subset_reset_o);
	c_int2: cover property (@(posedge ref_clk_i) disable iff (reset_i)
		!second_interrupt_pin_o);
endmodule
`default_nettype wire

// ### smc_pkg.sv
// Constants shared by the sensor mode-control block
package smc_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 50;
	localparam int DETECT_TIME_NS  = 1000000;
	localparam int DETECT_CYCLES   = (DETECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NOTIFY_LOW_NS   = 500;
	localparam int NOTIFY_LOW_CYC0 = NOTIFY_LOW_NS / CLK_PERIOD_NS;
	localparam int NOTIFY_LOW_CYCLES = (NOTIFY_LOW_CYC0 < 1) ? 1 : NOTIFY_LOW_CYC0;
	// ----------------------------------------------------------------
	// Data formats
	// ----------------------------------------------------------------
	localparam int RAW_W     = 16;
	localparam int TRIM_W    = 16;
	localparam int ACC_W     = 14;
	localparam int MAG_W     = 16;
	localparam int AXES      = 3;
	localparam int TRIM_WORDS = 2 * AXES;
	localparam int ACC_LO_PAD = 16 - ACC_W;
	// ----------------------------------------------------------------
	// Field encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] FS_2G      = 2'h0;
	localparam logic [1:0] FS_4G      = 2'h1;
	localparam logic [1:0] FS_8G      = 2'h2;
	localparam logic [1:0] MODS_HIRES = 2'h2;
endpackage

// ### smc_axis_comp.sv
// One axis of offset compensation, range scaling and saturation
`timescale 1ns/100ps
`default_nettype none
module smc_axis_comp #(
	parameter int IN_W  = 16,
	parameter int OUT_W = 14
) (
	input  wire logic                    ref_clk_i,
	input  wire logic                    reset_i,
	input  wire logic                    clk_en_i,
	input  wire logic                    load_i,
	input  wire logic signed [IN_W-1:0]  raw_i,
	input  wire logic signed [IN_W-1:0]  factory_off_i,
	input  wire logic signed [IN_W-1:0]  user_off_i,
	input  wire logic        [1:0]       shift_i,
	output logic signed      [OUT_W-1:0] comp_o
);
	initial begin
		if (OUT_W > IN_W || OUT_W < 8) $error("smc_axis_comp: OUT_W out of range");
	end

	localparam logic signed [IN_W+1:0] MAX_V = (IN_W+2)'((1 <<< (OUT_W-1)) - 1);
	localparam logic signed [IN_W+1:0] MIN_V = -(IN_W+2)'(1 <<< (OUT_W-1));

	logic signed [IN_W+1:0]  sum;
	logic signed [IN_W+1:0]  scaled;
	logic signed [OUT_W-1:0] comp_next;
	logic signed [OUT_W-1:0] comp_reg;

	// Factory trim first, user offset on top of it
	assign sum       = (IN_W+2)'(raw_i) + (IN_W+2)'(factory_off_i) + (IN_W+2)'(user_off_i);
	assign scaled    = sum >>> shift_i;
	assign comp_next = (scaled > MAX_V) ? MAX_V[OUT_W-1:0] :
	                   (scaled < MIN_V) ? MIN_V[OUT_W-1:0] : scaled[OUT_W-1:0];

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			comp_reg <= '0;
		end else if (clk_en_i && load_i) begin
			comp_reg <= comp_next;
		end
	end
	assign comp_o = comp_reg;
endmodule
`default_nettype wire

// ### smc_host_model.sv
// Host-side model: strap pin wiring, trim storage and framed serial clock
`timescale 1ns/100ps
`default_nettype none
module smc_host_model (
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	input  wire logic [1:0]  strap_mode_i,
	input  wire logic        strap_pull_up_i,
	input  wire logic        serial_out_i,
	input  wire logic        serial_out_oe_n_i,
	input  wire logic        frame_i,
	input  wire logic        trim_rd_i,
	input  wire logic [2:0]  trim_addr_i,
	output logic             pin_o,
	output logic             sclk_o,
	output logic [15:0]      trim_data_o,
	output logic             trim_valid_o
);
	logic [2:0] addr_q;
	int         wait_cnt;
	// A floating pin follows the weak pull; no other slave drives it
	always_comb begin
		if (strap_mode_i != 2'h2)
			pin_o = strap_mode_i[0];
		else if (!serial_out_oe_n_i)
			pin_o = serial_out_i;
		else
			pin_o = strap_pull_up_i;
	end
	// Clock stands low between frames; odd start offset keeps phase unrelated
	initial begin
		sclk_o = 1'b0;
		#13;
		forever #200 sclk_o <= frame_i ? ~sclk_o : 1'b0;
	end
	// Storage answers three cycles late; stale data is inverted, not held
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			wait_cnt <= 0;
			trim_valid_o <= 1'b0;
			trim_data_o <= 16'h0000;
			addr_q <= 3'h0;
		end else begin
			trim_valid_o <= 1'b0;
			if (trim_rd_i) begin
				addr_q <= trim_addr_i;
				wait_cnt <= 3;
			end else if (wait_cnt != 0) begin
				wait_cnt <= wait_cnt - 1;
				if (wait_cnt == 1) begin
					trim_valid_o <= 1'b1;
					trim_data_o <= 16'((int'(addr_q) + 1) * 16);
				end
			end else if (trim_valid_o) begin
				trim_data_o <= ~trim_data_o;
			end
		end
	end
endmodule
`default_nettype wire

// ### sensor_interface_and_mode_control_tb.sv
// Self-checking bench for the sensor mode-control block
`timescale 1ns/100ps
`default_nettype none
module sensor_interface_and_mode_control_tb
	import smc_pkg::*;
;
	logic ref_clk_i = 1'b0, reset_i = 1'b1, core_ok = 1'b0, soft_rst = 1'b0, frame = 1'b0;
	logic act = 1'b0, slp_rq = 1'b0, fast = 1'b0, ln = 1'b0, m8 = 1'b0, rv = 1'b0, sdo = 1'b0;
	logic [1:0] strap = 2'h2, fs = 2'h0, mods = 2'h0, ef;
	logic [2:0] mosr = 3'h0;
	logic [7:0] ev = 8'h00, rt = 8'h00;
	logic [15:0] rnd = 16'h02ed;
	logic [AXES-1:0][RAW_W-1:0] araw = '0, mraw = '0;
	logic [AXES-1:0][7:0] auo = '0;
	logic [AXES-1:0][15:0] muo = '0;
	wire logic [AXES-1:0][7:0] ahi, alo, mhi, mlo;
	wire logic pin, sclk, pull, so, so_oe_n, spi, bus_en, rise, first_interrupt_pin, int2, den, aen, subr;
	wire logic slp, trd, tval, skip, mwide;
	wire logic [2:0] taddr, mo;
	wire logic [1:0] efs, aosr;
	wire logic [15:0] tdata;
	int n_fail = 0, check_count = 0, low_run = 0, last_low = 0, rises = 0, srises = 0, subs = 0;
	logic [2:0] tq[$];

	smc_mode_ctrl #(.DETECT_CYC(20), .EVENTS(8)) DUT (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
		.clk_en_i(1'b1), .core_supply_ok_i(core_ok), .soft_reset_i(soft_rst),
		.addr_lsb_or_serial_out_pin_i(pin), .serial_out_data_i(sdo), .serial_sel_active_i(frame),
		.serial_clk_pin_i(sclk), .active_bit_i(act), .sleep_req_i(slp_rq), .events_i(ev),
		.route_to_second_i(rt), .trim_data_i(tdata), .trim_valid_i(tval), .fast_read_i(fast),
		.full_scale_i(fs), .low_noise_i(ln), .accel_mods_i(mods), .mag_osr_i(mosr),
		.mag_8bit_i(m8), .raw_valid_i(rv), .accel_raw_i(araw), .mag_raw_i(mraw),
		.accel_user_off_i(auo), .mag_user_off_i(muo), .strap_pull_up_o(pull), .serial_out_o(so),
		.serial_out_oe_n_o(so_oe_n), .spi_mode_o(spi), .bus_enable_o(bus_en),
		.serial_clk_rise_o(rise), .first_interrupt_pin_o(first_interrupt_pin), .second_interrupt_pin_o(int2),
		.digital_en_o(den), .analog_en_o(aen), .subset_reset_o(subr), .sleeping_o(slp),
		.trim_rd_o(trd), .trim_addr_o(taddr), .eff_full_scale_o(efs), .accel_osr_o(aosr),
		.mag_osr_o(mo), .skip_low_bytes_o(skip), .mag_wide_o(mwide), .accel_hi_o(ahi),
		.accel_lo_o(alo), .mag_hi_o(mhi), .mag_lo_o(mlo));
	smc_host_model host (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .strap_mode_i(strap),
		.strap_pull_up_i(pull), .serial_out_i(so), .serial_out_oe_n_i(so_oe_n), .frame_i(frame),
		.trim_rd_i(trd), .trim_addr_i(taddr), .pin_o(pin), .sclk_o(sclk), .trim_data_o(tdata),
		.trim_valid_o(tval));

	always #25 ref_clk_i = ~ref_clk_i;
	always @(posedge sclk) srises++;
	always @(posedge ref_clk_i) begin
		if (trd === 1'b1) tq.push_back(taddr);
		if (rise === 1'b1) rises++;
		if (subr === 1'b1) subs++;
		if (first_interrupt_pin === 1'b0) begin
			low_run++;
		end else begin
			if (low_run > 0) last_low = low_run;
			low_run = 0;
		end
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	// Bounded wait for the run state, then the trim fetch order
	task automatic wait_run();
		int i;
		i = 0;
		while (bus_en !== 1'b1 && i < 600) begin
			cyc(1);
			i++;
		end
		chk(16'(i < 600), 16'h0001);
		chk(16'(tq.size()), 16'h0006);
		foreach (tq[j]) chk(16'(tq[j]), 16'(j));
		tq.delete();
	endtask
	task automatic restart(input logic [1:0] m);
		strap = m;
		soft_rst = 1'b1;
		cyc(1);
		soft_rst = 1'b0;
		cyc(3);
		wait_run();
		chk(16'(spi), 16'(m == 2'h2));
		chk(16'(last_low), 16'(NOTIFY_LOW_CYCLES - 1));
		chk(16'(first_interrupt_pin), 16'h0001);
		$display("restart with strap %0d done", m);
	endtask

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		int v;
		repeat (6) @(posedge ref_clk_i);
		@(negedge ref_clk_i) reset_i = 1'b0;
		cyc(1);
		core_ok = 1'b1;
		wait_run();
		chk(16'(spi), 16'h0001);
		chk(16'(first_interrupt_pin), 16'h0001);
		$display("power-up done");
		for (int m = 0; m < 3; m++) restart(2'(m));
		strap = 2'h0;
		cyc(30);
		chk(16'(spi), 16'h0001);
		rises = 0;
		srises = 0;
		frame = 1'b1;
		cyc(40);
		chk(16'(so_oe_n), 16'h0000);
		frame = 1'b0;
		cyc(12);
		chk(16'(rises), 16'(srises));
		$display("latch and serial clock done");
		slp_rq = 1'b1;
		cyc(4);
		chk(16'({den, aen, slp}), 16'h0004);
		subs = 0;
		act = 1'b1;
		cyc(6);
		chk(16'({den, aen, slp}), 16'h0007);
		chk(16'(subs), 16'h0001);
		act = 1'b0;
		cyc(4);
		act = 1'b1;
		cyc(4);
		$display("modes done");
		for (int k = 0; k < 24; k++) begin
			fs = 2'(k % 3);
			ln = k[3];
			fast = k[0];
			m8 = k[1];
			mods = 2'(k);
			mosr = 3'(k);
			for (int a = 0; a < AXES; a++) begin
				rnd = lfsr(rnd);
				araw[a] = {{6{rnd[9]}}, rnd[9:0]};
				rnd = lfsr(rnd);
				auo[a] = rnd[7:0];
				mraw[a] = rnd;
				muo[a] = ~rnd;
			end
			rnd = lfsr(rnd);
			ev = rnd[7:0];
			rt = rnd[15:8];
			sdo = rnd[0];
			rv = 1'b1;
			cyc(1);
			rv = 1'b0;
			cyc(3);
			ef = (ln && fs == FS_8G) ? FS_4G : fs;
			chk(16'(efs), 16'(ef));
			chk(16'({skip, aosr, mo, mwide}), 16'({fast, mods, mosr, !m8}));
			chk(16'(int2), 16'(!(|(ev & rt))));
			for (int a = 0; a < AXES; a++) begin
				v = ($signed(araw[a]) + (a + 1) * 16 + $signed(auo[a])) >>> ef;
				if (v > 8191) v = 8191;
				if (v < -8192) v = -8192;
				chk({ahi[a], alo[a]}, {v[13:0], 2'h0});
				chk({mhi[a], mlo[a]}, 16'((a + 4) * 16 - 1));
			end
		end
		$display("data formatting done");
		core_ok = 1'b0;
		cyc(6);
		chk(16'({bus_en, aen, den}), 16'h0000);
		strap = 2'h1;
		core_ok = 1'b1;
		cyc(3);
		wait_run();
		chk(16'(spi), 16'h0000);
		$display("supply cycle done");
		summarize();
	end
	initial begin
		#300000;
		n_fail++;
		$display("BAD %0t watchdog expired", $time);
		summarize();
	end
endmodule
`default_nettype wire
